/* File: common/betx_pkg.sv */
/*
  constants and types shared by the bit and transfer execution unit
  assumes: an 8-bit core with 32 working registers and a small data memory
*/
package betx_pkg;
  localparam int DATA_W       = 8;
  localparam int NUM_REGS     = 32;
  localparam int MEM_DEPTH    = 64;
  localparam int MEM_AW       = 6;
  // low register of each pointer pair
  localparam logic [4:0] PTR_A_LO = 5'h1A;
  localparam logic [4:0] PTR_B_LO = 5'h1C;
  localparam logic [4:0] PTR_C_LO = 5'h1E;
  // bit positions in the status flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // register port map: 0x00..0x1F working registers, status flags
  localparam logic [7:0] BUS_REGS_LAST = 8'h1F;
  localparam logic [7:0] BUS_STATUS    = 8'h3F;
  // execution times in cycles
  localparam int SINGLE_CYCLES = 1;
  localparam int MEM_CYCLES    = 2;

  typedef enum logic [3:0] {
    OP_NOP                  = 4'h0,
    OP_ROTATE_RIGHT_CARRY   = 4'h1,
    OP_ARITH_SHIFT_RIGHT    = 4'h2,
    OP_NIBBLE_SWAP          = 4'h3,
    OP_FLAG_SET_INDEXED     = 4'h4,
    OP_FLAG_CLEAR_INDEXED   = 4'h5,
    OP_BIT_TO_TRANSFER_FLAG = 4'h6,
    OP_TRANSFER_FLAG_TO_BIT = 4'h7,
    OP_REG_COPY             = 4'h8,
    OP_REG_PAIR_COPY        = 4'h9,
    OP_IMMEDIATE_LOAD       = 4'hA,
    OP_INDIRECT_LOAD        = 4'hB,
    OP_DISPLACED_LOAD       = 4'hC,
    OP_DIRECT_LOAD          = 4'hD,
    OP_INDIRECT_STORE       = 4'hE,
    OP_DISPLACED_STORE      = 4'hF
  } betx_op_type;

  typedef enum logic [1:0] {
    PTR_A = 2'h0,
    PTR_B = 2'h1,
    PTR_C = 2'h2
  } betx_ptr_type;

  typedef enum logic [1:0] {
    MODE_PLAIN    = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_PRE_DEC  = 2'h2
  } betx_mode_type;

  typedef enum logic [0:0] {
    STATE_IDLE = 1'b0,
    STATE_MEM  = 1'b1
  } betx_state_type;
endpackage : betx_pkg

/* File: common/betx_mem_if.sv */
/*
  data memory port between the execution unit and its memory
  assumes: one synchronous port, read data one cycle after the request
*/
`timescale 1ns/10ps
interface betx_mem_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       we;
  logic       re;
  modport unit (output addr, output wdata, output we, output re,
                input rdata);
  modport mem  (input addr, input wdata, input we, input re,
                output rdata);
endinterface : betx_mem_if

/* File: logic/betx_dmem.sv */
/*
  internal data memory of the execution unit
  assumes: single clock, synchronous active-high reset clears all bytes
*/
`timescale 1ns/10ps
module betx_dmem (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  betx_mem_if.mem   mem_port
);
  import betx_pkg::*;

  logic [MEM_DEPTH-1:0][7:0] mem_q;
  logic [MEM_DEPTH-1:0][7:0] mem_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;

  // write lands at the edge, read data appear the cycle after
  always_comb begin
    mem_d   = mem_q;
    rdata_d = rdata_q;
    if (mem_port.we) begin
      mem_d[mem_port.addr] = mem_port.wdata;
    end
    if (mem_port.re) begin
      rdata_d = mem_q[mem_port.addr];
    end
  end

  // storage registers
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mem_q   <= '0;
      rdata_q <= REG_RESET;
    end else begin
      mem_q   <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign mem_port.rdata = rdata_q;
endmodule : betx_dmem

/* File: logic/betx_exec.sv */
/*
  execution unit for bit manipulation and data transfer instructions
  assumes: one core clock; the decoder holds a request until ready;
  the register port master never writes and reads in one cycle
*/
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - rotate right through carry: carry to bit 7, bit 0 to carry
// - arithmetic shift right keeps bit 7, bit 0 to carry
// - bit store copies a register bit into the transfer flag
// - bit load writes the transfer flag into a register bit
// - indexed set and clear change only the addressed flag
// - register copy and pair copy, one cycle, no flags
// - first pointer load with post-increment, two cycles
// - first pointer load with pre-decrement, two cycles
// - second pointer load with post-increment, no flags
// - third pointer load with pre-decrement, two cycles
// - displaced load reads pointer plus offset, pointer kept
// - direct load reads the address in the instruction, two cycles
// - store with post-increment writes then bumps pointer
// - store with pre-decrement lowers pointer then writes
// - displaced store writes pointer plus offset, pointer kept
module betx_exec (
  input  wire logic                   ref_clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   op_valid_in,
  input  wire betx_pkg::betx_op_type  op_code_in,
  input  wire logic [4:0]             op_dst_in,
  input  wire logic [4:0]             op_src_in,
  input  wire logic [2:0]             op_bit_in,
  input  wire logic [7:0]             op_imm_in,
  input  wire logic [5:0]             op_disp_in,
  input  wire logic [15:0]            op_addr_in,
  input  wire betx_pkg::betx_ptr_type op_ptr_in,
  input  wire betx_pkg::betx_mode_type op_mode_in,
  output logic                        op_ready_out,
  output logic                        op_done_out,
  output logic                        irq_enable_out,
  output logic [7:0]                  status_flags_out,
  input  wire logic [7:0]             bus_addr_in,
  input  wire logic [7:0]             bus_wdata_in,
  input  wire logic                   bus_wr_in,
  input  wire logic                   bus_rd_in,
  output logic [7:0]                  bus_rdata_out
);
  import betx_pkg::*;

  // low register index of a pointer pair
  function automatic logic [4:0] ptr_lo(input betx_ptr_type sel);
    unique case (sel)
      PTR_A:   ptr_lo = PTR_A_LO;
      PTR_B:   ptr_lo = PTR_B_LO;
      PTR_C:   ptr_lo = PTR_C_LO;
      default: ptr_lo = PTR_C_LO;
    endcase
  endfunction : ptr_lo

  // 16-bit value of a pointer pair
  function automatic logic [15:0] ptr_get(
    input logic [NUM_REGS-1:0][7:0] rf, input betx_ptr_type sel);
    logic [4:0] lo;
    lo = ptr_lo(sel);
    ptr_get = {rf[lo | 5'h01], rf[lo]};
  endfunction : ptr_get

  // zero, carry, negative, overflow after a right shift
  function automatic logic [7:0] shift_flags(
    input logic [7:0] sr, input logic [7:0] res, input logic cout);
    logic [7:0] f;
    f = sr;
    f[FLAG_C] = cout;
    f[FLAG_Z] = (res == 8'h00);
    f[FLAG_N] = res[7];
    f[FLAG_V] = res[7] ^ cout;
    shift_flags = f;
  endfunction : shift_flags

  betx_mem_if mem_bus ();

  betx_dmem u_dmem (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .mem_port   (mem_bus.mem)
  );

  betx_state_type             state_q;
  betx_state_type             state_d;
  logic [NUM_REGS-1:0][7:0]   rf_q;
  logic [NUM_REGS-1:0][7:0]   rf_d;
  logic [7:0]                 flags_q;
  logic [7:0]                 flags_d;
  logic                       done_q;
  logic                       done_d;
  logic                       load_q;
  logic                       load_d;
  logic [4:0]                 load_dst_q;
  logic [4:0]                 load_dst_d;
  logic [7:0]                 rdata_q;
  logic [7:0]                 rdata_d;
  logic                       accept;
  logic [7:0]                 dval;
  logic [7:0]                 sval;
  logic [15:0]                ptr;
  logic [15:0]                ptr_new;
  logic [15:0]                eff_addr;
  logic [4:0]                 plo;

  assign accept = op_valid_in && (state_q == STATE_IDLE);
  assign dval   = rf_q[op_dst_in];
  assign sval   = rf_q[op_src_in];
  assign ptr    = ptr_get(rf_q, op_ptr_in);
  assign plo    = ptr_lo(op_ptr_in);

  // next state of registers, flags and memory request
  always_comb begin
    state_d         = state_q;
    rf_d            = rf_q;
    flags_d         = flags_q;
    done_d          = 1'b0;
    load_d          = load_q;
    load_dst_d      = load_dst_q;
    rdata_d         = rdata_q;
    ptr_new         = ptr;
    eff_addr        = ptr;
    mem_bus.addr    = '0;
    mem_bus.wdata   = sval;
    mem_bus.we      = 1'b0;
    mem_bus.re      = 1'b0;
    // register port: read data in the following cycle only
    rdata_d = 8'h00;
    if (bus_rd_in) begin
      if (bus_addr_in <= BUS_REGS_LAST) begin
        rdata_d = rf_q[bus_addr_in[4:0]];
      end else if (bus_addr_in == BUS_STATUS) begin
        rdata_d = flags_q;
      end
    end
    if (bus_wr_in) begin
      if (bus_addr_in <= BUS_REGS_LAST) begin
        rf_d[bus_addr_in[4:0]] = bus_wdata_in;
      end else if (bus_addr_in == BUS_STATUS) begin
        flags_d = bus_wdata_in;
      end
    end
    // second cycle of a memory access: load result lands
    if (state_q == STATE_MEM) begin
      if (load_q) begin
        rf_d[load_dst_q] = mem_bus.rdata;
      end
      done_d  = 1'b1;
      state_d = STATE_IDLE;
    end
    if (accept) begin
      unique case (op_code_in)
        OP_ROTATE_RIGHT_CARRY: begin
          rf_d[op_dst_in] = {flags_q[FLAG_C], dval[7:1]};
          flags_d = shift_flags(flags_q, {flags_q[FLAG_C], dval[7:1]},
                                dval[0]);
        end
        OP_ARITH_SHIFT_RIGHT: begin
          rf_d[op_dst_in] = {dval[7], dval[7:1]};
          flags_d = shift_flags(flags_q, {dval[7], dval[7:1]},
                                dval[0]);
        end
        OP_NIBBLE_SWAP: begin
          rf_d[op_dst_in] = {dval[3:0], dval[7:4]};
        end
        OP_FLAG_SET_INDEXED: begin
          flags_d[op_bit_in] = 1'b1;
        end
        OP_FLAG_CLEAR_INDEXED: begin
          flags_d[op_bit_in] = 1'b0;
        end
        OP_BIT_TO_TRANSFER_FLAG: begin
          flags_d[FLAG_T] = sval[op_bit_in];
        end
        OP_TRANSFER_FLAG_TO_BIT: begin
          rf_d[op_dst_in][op_bit_in] = flags_q[FLAG_T];
        end
        OP_REG_COPY: begin
          rf_d[op_dst_in] = sval;
        end
        OP_REG_PAIR_COPY: begin
          rf_d[{op_dst_in[4:1], 1'b0}] = rf_q[{op_src_in[4:1], 1'b0}];
          rf_d[{op_dst_in[4:1], 1'b1}] = rf_q[{op_src_in[4:1], 1'b1}];
        end
        OP_IMMEDIATE_LOAD: begin
          rf_d[op_dst_in] = op_imm_in;
        end
        OP_INDIRECT_LOAD, OP_INDIRECT_STORE: begin
          // pre-decrement addresses with the lowered pointer
          if (op_mode_in == MODE_PRE_DEC) begin
            ptr_new  = ptr - 16'h0001;
            eff_addr = ptr_new;
          end else if (op_mode_in == MODE_POST_INC) begin
            ptr_new  = ptr + 16'h0001;
          end
          rf_d[plo]         = ptr_new[7:0];
          rf_d[plo | 5'h01] = ptr_new[15:8];
        end
        OP_DISPLACED_LOAD, OP_DISPLACED_STORE: begin
          eff_addr = ptr + {10'h000, op_disp_in};
        end
        OP_DIRECT_LOAD: begin
          eff_addr = op_addr_in;
        end
        default: begin
        end
      endcase
      // memory instructions take a second cycle
      if (op_code_in >= OP_INDIRECT_LOAD) begin
        mem_bus.addr = eff_addr[MEM_AW-1:0];
        load_d       = (op_code_in < OP_INDIRECT_STORE);
        mem_bus.re   = load_d;
        mem_bus.we   = !load_d;
        load_dst_d   = op_dst_in;
        state_d      = STATE_MEM;
      end else begin
        done_d = 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q    <= STATE_IDLE;
      rf_q       <= '0;
      flags_q    <= STATUS_RESET;
      done_q     <= 1'b0;
      load_q     <= 1'b0;
      load_dst_q <= 5'h00;
      rdata_q    <= 8'h00;
    end else begin
      state_q    <= state_d;
      rf_q       <= rf_d;
      flags_q    <= flags_d;
      done_q     <= done_d;
      load_q     <= load_d;
      load_dst_q <= load_dst_d;
      rdata_q    <= rdata_d;
    end
  end

  assign op_ready_out     = (state_q == STATE_IDLE);
  assign op_done_out      = done_q;
  assign irq_enable_out   = flags_q[FLAG_I];
  assign status_flags_out = flags_q;
  assign bus_rdata_out    = rdata_q;

  // capture of each accepted request for the checks below
  logic        chk_v_q;
  logic        chk_bus_q;
  betx_op_type chk_op_q;
  logic [4:0]  chk_dst_q;
  logic [2:0]  chk_bit_q;
  logic [7:0]  chk_imm_q;
  logic [7:0]  chk_d_q;
  logic [7:0]  chk_s_q;
  logic [7:0]  chk_sr_q;
  logic [15:0] chk_ptr_q;
  betx_ptr_type chk_psel_q;
  betx_mode_type chk_mode_q;
  logic        chk_ok;

  always_ff @(posedge ref_clk_in) begin
    chk_v_q    <= accept && !sys_rst_in;
    chk_bus_q  <= bus_wr_in;
    chk_op_q   <= op_code_in;
    chk_dst_q  <= op_dst_in;
    chk_bit_q  <= op_bit_in;
    chk_imm_q  <= op_imm_in;
    chk_d_q    <= dval;
    chk_s_q    <= sval;
    chk_sr_q   <= flags_q;
    chk_ptr_q  <= ptr;
    chk_psel_q <= op_ptr_in;
    chk_mode_q <= op_mode_in;
  end
  assign chk_ok = chk_v_q && !chk_bus_q;

  a_rotate_result: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_ROTATE_RIGHT_CARRY |->
      rf_q[chk_dst_q] == {chk_sr_q[FLAG_C], chk_d_q[7:1]} &&
      flags_q[FLAG_C] == chk_d_q[0] && done_q)
    else $error("rotate result or carry wrong");
  a_shift_result: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_ARITH_SHIFT_RIGHT |->
      rf_q[chk_dst_q] == {chk_d_q[7], chk_d_q[7:1]} &&
      flags_q[FLAG_Z] == (rf_q[chk_dst_q] == 8'h00))
    else $error("arithmetic shift result wrong");
  a_swap_no_flags: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_NIBBLE_SWAP |->
      rf_q[chk_dst_q] == {chk_d_q[3:0], chk_d_q[7:4]} && flags_q == chk_sr_q)
    else $error("nibble swap wrong");
  a_tflag_store_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_BIT_TO_TRANSFER_FLAG |->
      flags_q[FLAG_T] == chk_s_q[chk_bit_q] &&
      (flags_q ^ chk_sr_q) == ((flags_q ^ chk_sr_q) & 8'h40))
    else $error("bit store to transfer flag wrong");
  a_tflag_load_bit: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_TRANSFER_FLAG_TO_BIT |->
      rf_q[chk_dst_q][chk_bit_q] == chk_sr_q[FLAG_T] && flags_q == chk_sr_q)
    else $error("transfer flag to bit wrong");
  a_flag_single_bit: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_FLAG_SET_INDEXED |->
      flags_q == (chk_sr_q | (8'h01 << chk_bit_q)) && done_q)
    else $error("flag set touched other flags");
  a_flag_clear_bit: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && chk_op_q == OP_FLAG_CLEAR_INDEXED |->
      flags_q == (chk_sr_q & ~(8'h01 << chk_bit_q)))
    else $error("flag clear touched other flags");
  a_copy_imm_value: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && (chk_op_q == OP_REG_COPY || chk_op_q == OP_IMMEDIATE_LOAD) |->
      rf_q[chk_dst_q] == (chk_op_q == OP_REG_COPY ? chk_s_q : chk_imm_q) &&
      flags_q == chk_sr_q)
    else $error("copy or immediate load wrong");
  a_mem_two_cycles: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    accept && op_code_in >= OP_INDIRECT_LOAD |=>
      !op_done_out && !op_ready_out ##1 op_done_out && op_ready_out)
    else $error("memory instruction not two cycles");
  a_ptr_step: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && (chk_op_q == OP_INDIRECT_LOAD || chk_op_q == OP_INDIRECT_STORE)
      && chk_mode_q == MODE_POST_INC && chk_dst_q[4:1] != ptr_lo(chk_psel_q) >> 1
      |-> ptr_get(rf_q, chk_psel_q) == chk_ptr_q + 16'h0001)
    else $error("pointer not incremented");
  a_disp_ptr_kept: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    chk_ok && (chk_op_q inside {OP_DISPLACED_LOAD, OP_DISPLACED_STORE}) |->
      ptr_get(rf_q, chk_psel_q) == chk_ptr_q && flags_q == chk_sr_q)
    else $error("displacement changed the pointer");
  a_store_we_addr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    accept && op_code_in == OP_INDIRECT_STORE && op_mode_in == MODE_PRE_DEC
      |-> mem_bus.we && mem_bus.addr == MEM_AW'(ptr - 16'h0001))
    else $error("pre-decrement store address wrong");
endmodule : betx_exec

/* File: verification/betx_issuer.sv */
/*
  instruction issuer in place of the core decoder
  assumes: ready and done come straight from the execution unit
*/
`timescale 1ns/10ps
module betx_issuer (
  input  wire logic               ref_clk_in,
  input  wire logic               op_ready_in,
  input  wire logic               op_done_in,
  output logic                    op_valid_out,
  output betx_pkg::betx_op_type   op_code_out,
  output logic [4:0]              op_dst_out,
  output logic [4:0]              op_src_out,
  output logic [2:0]              op_bit_out,
  output logic [7:0]              op_imm_out,
  output logic [5:0]              op_disp_out,
  output logic [15:0]             op_addr_out,
  output betx_pkg::betx_ptr_type  op_ptr_out,
  output betx_pkg::betx_mode_type op_mode_out
);
  import betx_pkg::*;

  // idle request port at time zero
  initial begin
    op_valid_out = 1'b0;
    op_code_out = OP_NOP;
    {op_dst_out, op_src_out, op_bit_out, op_imm_out} = '0;
    {op_disp_out, op_addr_out} = '0;
    op_ptr_out = PTR_A;
    op_mode_out = MODE_PLAIN;
  end

  // hold the request until taken, then count edges to done
  task automatic issue(input betx_op_type c, input logic [4:0] d, s,
      input logic [2:0] b, input logic [7:0] k, input logic [5:0] q,
      input logic [15:0] a, input betx_ptr_type p,
      input betx_mode_type m, output int lat);
    @(posedge ref_clk_in);
    op_valid_out <= 1'b1;
    op_code_out <= c;
    op_dst_out <= d;
    op_src_out <= s;
    op_bit_out <= b;
    op_imm_out <= k;
    op_disp_out <= q;
    op_addr_out <= a;
    op_ptr_out <= p;
    op_mode_out <= m;
    do @(posedge ref_clk_in); while (op_ready_in !== 1'b1);
    // released dst, src, imm and addr fields carry garbage, not the last value
    op_valid_out <= 1'b0;
    op_dst_out <= ~d;
    op_src_out <= ~s;
    op_imm_out <= ~k;
    op_addr_out <= ~a;
    lat = 0;
    do begin
      @(posedge ref_clk_in);
      lat++;
    end while (op_done_in !== 1'b1 && lat < 8);
  endtask : issue
endmodule : betx_issuer

/* File: verification/bit_and_transfer_exec_unit_tb.sv */
/*
  self-checking bench: corner cases then random instructions
  assumes: issuer drives the instruction port, bench the register bus
*/
`timescale 1ns/10ps
module bit_and_transfer_exec_unit_tb;
  import betx_pkg::*;
  logic          ref_clk_in, sys_rst_in, op_valid, op_ready, op_done;
  logic          irq_en, bus_wr, bus_rd;
  logic [7:0]    flags_out, bus_addr, bus_wdata, bus_rdata, imm, rd;
  logic [4:0]    dst, src;
  logic [2:0]    bsel;
  logic [5:0]    disp;
  logic [15:0]   addr;
  betx_op_type   code, c;
  betx_ptr_type  ptr;
  betx_mode_type mode, md;
  logic [7:0]    rf [NUM_REGS];
  logic [7:0]    mem [MEM_DEPTH];
  logic [7:0]    sr;
  int            num_errors, comparisons, cyc;
  logic [7:0]    vals [4] = '{8'h01, 8'h80, 8'h00, 8'hFF};

  betx_exec u_betx_exec (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .op_valid_in(op_valid), .op_code_in(code), .op_dst_in(dst),
    .op_src_in(src), .op_bit_in(bsel), .op_imm_in(imm),
    .op_disp_in(disp), .op_addr_in(addr), .op_ptr_in(ptr),
    .op_mode_in(mode), .op_ready_out(op_ready), .op_done_out(op_done),
    .irq_enable_out(irq_en), .status_flags_out(flags_out),
    .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_wr_in(bus_wr),
    .bus_rd_in(bus_rd), .bus_rdata_out(bus_rdata));

  betx_issuer u_betx_issuer (.ref_clk_in(ref_clk_in), .op_ready_in(op_ready),
    .op_done_in(op_done), .op_valid_out(op_valid), .op_code_out(code),
    .op_dst_out(dst), .op_src_out(src), .op_bit_out(bsel),
    .op_imm_out(imm), .op_disp_out(disp), .op_addr_out(addr),
    .op_ptr_out(ptr), .op_mode_out(mode));

  // clock of 100 ns
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // hang guard, far above the expected run length
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run hangs", $time);
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic bus_write(input logic [7:0] a, w);
    @(posedge ref_clk_in);
    bus_addr <= a;
    bus_wdata <= w;
    bus_wr <= 1'b1;
    @(posedge ref_clk_in);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~w;
  endtask : bus_write

  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, output logic [7:0] r);
    @(posedge ref_clk_in);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk_in);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    @(posedge ref_clk_in);
    r = bus_rdata;
  endtask : bus_read

  task automatic check_reg(input logic [4:0] i);
    bus_read({3'h0, i}, rd);
    chk({8'h00, rd}, {8'h00, rf[i]}, "register");
  endtask : check_reg

  task automatic check_all();
    for (int i = 0; i < NUM_REGS; i++)
      check_reg(5'(i));
    bus_read(BUS_STATUS, rd);
    chk({8'h00, rd}, {8'h00, sr}, "status read");
  endtask : check_all

  // shift result: flags Z C N V, V = N xor C
  task automatic shift(input logic [7:0] r, input logic [4:0] d);
    sr[FLAG_C] = rf[d][0];
    sr[FLAG_Z] = (r == 8'h00);
    sr[FLAG_N] = r[7];
    sr[FLAG_V] = r[7] ^ rf[d][0];
    rf[d] = r;
  endtask : shift

  // expected effect of one instruction on registers, flags, memory
  task automatic model(input betx_op_type c, input logic [4:0] d, s,
      input logic [2:0] b, input logic [7:0] k, input logic [5:0] q,
      input logic [15:0] a, input betx_ptr_type p, input betx_mode_type m);
    logic [7:0]  v;
    logic [15:0] pt;
    logic [4:0]  lo;
    logic [5:0]  ea;
    v = rf[s];
    lo = (p == PTR_A) ? PTR_A_LO : (p == PTR_B) ? PTR_B_LO : PTR_C_LO;
    pt = {rf[lo + 5'd1], rf[lo]};
    if (m == MODE_PRE_DEC)
      pt = pt - 16'h0001;
    ea = (c == OP_DIRECT_LOAD) ? a[5:0] : pt[5:0];
    if (c inside {OP_DISPLACED_LOAD, OP_DISPLACED_STORE})
      ea = ea + q;
    if (c inside {OP_INDIRECT_LOAD, OP_INDIRECT_STORE} && m != MODE_PLAIN) begin
      if (m == MODE_POST_INC)
        pt = pt + 16'h0001;
      {rf[lo + 5'd1], rf[lo]} = pt;
    end
    case (c)
      OP_ROTATE_RIGHT_CARRY: shift({sr[FLAG_C], rf[d][7:1]}, d);
      OP_ARITH_SHIFT_RIGHT: shift({rf[d][7], rf[d][7:1]}, d);
      OP_NIBBLE_SWAP: rf[d] = {rf[d][3:0], rf[d][7:4]};
      OP_FLAG_SET_INDEXED: sr[b] = 1'b1;
      OP_FLAG_CLEAR_INDEXED: sr[b] = 1'b0;
      OP_BIT_TO_TRANSFER_FLAG: sr[FLAG_T] = v[b];
      OP_TRANSFER_FLAG_TO_BIT: rf[d][b] = sr[FLAG_T];
      OP_REG_COPY: rf[d] = v;
      OP_REG_PAIR_COPY: begin
        rf[{d[4:1], 1'b0}] = rf[{s[4:1], 1'b0}];
        rf[{d[4:1], 1'b1}] = rf[{s[4:1], 1'b1}];
      end
      OP_IMMEDIATE_LOAD: rf[d] = k;
      OP_INDIRECT_LOAD, OP_DISPLACED_LOAD, OP_DIRECT_LOAD: rf[d] = mem[ea];
      OP_INDIRECT_STORE, OP_DISPLACED_STORE: mem[ea] = v;
      default: ;
    endcase
  endtask : model

  // issue, model, then check cycle count and flags at done
  task automatic run(input betx_op_type c, input logic [4:0] d = 0,
      s = 0, input logic [2:0] b = 0, input logic [7:0] k = 0,
      input logic [5:0] q = 0, input logic [15:0] a = 0,
      input betx_ptr_type p = PTR_A, input betx_mode_type m = MODE_PLAIN);
    int lat;
    u_betx_issuer.issue(c, d, s, b, k, q, a, p, m, lat);
    model(c, d, s, b, k, q, a, p, m);
    chk(16'(lat), 16'(c >= OP_INDIRECT_LOAD ? MEM_CYCLES : SINGLE_CYCLES),
        "cycles");
    chk({8'h00, flags_out}, {8'h00, sr}, "flags");
    chk({15'h0, irq_en}, {15'h0, sr[FLAG_I]}, "irq enable");
  endtask : run

  task automatic wr_reg(input logic [4:0] i, input logic [7:0] v);
    bus_write({3'h0, i}, v);
    rf[i] = v;
  endtask : wr_reg

  initial begin
    {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    {num_errors, comparisons, cyc} = '0;
    sr = STATUS_RESET;
    foreach (rf[i]) rf[i] = REG_RESET;
    foreach (mem[i]) mem[i] = 8'h00;
    sys_rst_in = 1'b1;
    void'($urandom(32'h35adc1b7));
    repeat (10) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    check_all();
    bus_write(8'h25, 8'hA5);
    bus_read(8'h25, rd);
    chk({8'h00, rd}, 16'h0000, "unmapped read");
    bus_write(BUS_STATUS, 8'hC3);
    sr = 8'hC3;
    bus_read(BUS_STATUS, rd);
    chk({8'h00, rd}, {8'h00, sr}, "status write");
    chk({15'h0, irq_en}, 16'h0001, "irq after write");
    $display("test reset and bus done");
    for (int i = 0; i < NUM_REGS; i++)
      wr_reg(5'(i), 8'($urandom));
    foreach (vals[i]) for (int j = 0; j < 6; j++) begin
      run(OP_IMMEDIATE_LOAD, 5'd7, , , vals[i]);
      run(j[0] ? OP_FLAG_SET_INDEXED : OP_FLAG_CLEAR_INDEXED, , , 3'(FLAG_C));
      run(betx_op_type'(j / 2 + 1), 5'd7);
      check_reg(5'd7);
    end
    $display("test shifts done");
    for (int b = 0; b < 8; b++) begin
      run(OP_FLAG_SET_INDEXED, , , 3'(b));
      run(OP_FLAG_CLEAR_INDEXED, , , 3'(b ^ 3));
      run(OP_BIT_TO_TRANSFER_FLAG, , 5'd5, 3'(b));
      run(OP_TRANSFER_FLAG_TO_BIT, 5'd9, , 3'(7 - b));
      check_reg(5'd9);
    end
    run(OP_REG_COPY, 5'd10, 5'd5);
    run(OP_REG_PAIR_COPY, 5'd13, 5'd5);
    check_all();
    $display("test flags and copies done");
    wr_reg(5'd26, 8'hFF);
    wr_reg(5'd27, 8'h00);
    wr_reg(5'd28, 8'h00);
    wr_reg(5'd29, 8'h00);
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 3; m++) begin
        run(OP_INDIRECT_STORE, , 5'($urandom_range(25)), , , , ,
            betx_ptr_type'(p), betx_mode_type'(m));
        run(OP_INDIRECT_LOAD, 5'($urandom_range(25)), , , , , ,
            betx_ptr_type'(p), betx_mode_type'(m));
        check_all();
      end
      run(OP_DISPLACED_STORE, , 5'(p + 1), , , 6'h3F, , betx_ptr_type'(p));
      run(OP_DISPLACED_LOAD, 5'(p + 20), , , , 6'h3F, , betx_ptr_type'(p));
      check_all();
    end
    run(OP_DIRECT_LOAD, 5'd3, , , , , 16'hFFFF);
    check_reg(5'd3);
    $display("test memory transfers done");
    for (int n = 0; n < 300; n++) begin
      c = betx_op_type'($urandom_range(15, 1));
      md = MODE_PLAIN;
      if (c inside {OP_INDIRECT_LOAD, OP_INDIRECT_STORE})
        md = betx_mode_type'($urandom_range(2));
      run(c, 5'($urandom), 5'($urandom_range(c >= OP_INDIRECT_STORE ? 25 : 31)),
          3'($urandom), 8'($urandom), 6'($urandom), 16'($urandom),
          betx_ptr_type'($urandom_range(2)), md);
      if (n % 10 == 9)
        check_all();
    end
    $display("test random done");
    test_done();
  end
endmodule : bit_and_transfer_exec_unit_tb
